// ==== design/dcc_pkg.sv ====
// Package for the dual oscillator clock control block
package dcc_pkg;

  // ----------------------------------------------------------------
  // Register map, word index and address width
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_PWR_CLK_IDX   = 8'he8;
  localparam logic [7:0]  REG_OSC_SRC_IDX   = 8'hef;
  localparam logic [7:0]  REG_CLK_STAT_IDX  = 8'hf0;
  localparam int          ADR_W             = 12;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          PCC_FAST_DIS      = 0;
  localparam int          PCC_SLOW_EN       = 1;
  localparam int          PCC_SEL_SLOW      = 2;
  localparam int          PCC_DIV_LO        = 3;
  localparam int          PCC_T2_WAKE       = 6;
  localparam int          PCC_PDN           = 7;
  localparam int          OSC_RC_SEL        = 2;
  localparam int          OSC_LOCK          = 7;

  // ----------------------------------------------------------------
  // Reset values and divisor codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  PCC_RESET         = 8'h08;
  localparam logic [7:0]  OSC_SRC_RESET     = 8'h00;
  localparam logic [1:0]  DIV_BY2           = 2'h0;
  localparam logic [1:0]  DIV_BY1           = 2'h1;
  localparam logic [1:0]  DIV_BY8           = 2'h2;
  localparam logic [1:0]  DIV_BY256         = 2'h3;
  localparam int          PLL_MULT          = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_SYS_HZ        = 20000000;
  localparam int          WAKE_DLY_MIN_MS   = 10;
  localparam int          WAKE_DLY_MAX_MS   = 20;
  localparam int          WAKE_DLY_CYC      =
    (WAKE_DLY_MIN_MS * CLK_SYS_HZ + 999) / 1000;
  localparam int          DLY_W             = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WS_RUN,
    WS_DOWN,
    WS_FAST_DLY,
    WS_SLOW_WAIT
  } dcc_wake_e;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } dcc_wb_req_s;

  typedef struct packed {
    logic              ack;
    logic [31:0]       dat;
  } dcc_wb_rsp_s;

  typedef struct packed {
    logic              pclk_en;
    logic              ram_cyc_en;
    logic              code_cyc_en;
    logic              fast_clk_en;
    logic              filter_clk_en;
    logic              analog_front_end_clk_en;
    logic              l1_clk_en;
    logic              timer1_clk_en;
    logic              timer3_clk_en;
    logic              mt_timer_clk_en;
    logic              timer2_clk_en;
    logic              wdt_clk_en;
    logic              audio_wake_clk_en;
  } dcc_clk_s;

  typedef struct packed {
    logic              fast_osc_en;
    logic              pll_en;
    logic              slow_osc_en;
    logic              slow_src_rc;
    logic              cpu_hold;
    logic              pdn;
  } dcc_osc_s;

endpackage

// ==== design/dcc_clock_control.sv ====
// Dual oscillator clock control with Wishbone register access
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
module dcc_clock_control #(
  parameter int WAKE_DELAY_CYC = dcc_pkg::WAKE_DLY_CYC
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire dcc_pkg::dcc_wb_req_s wb_req,
  output      dcc_pkg::dcc_wb_rsp_s wb_rsp,
  input  wire logic                fast_osc_tick,
  input  wire logic                slow_osc_tick,
  input  wire logic                slow_osc_stable,
  input  wire logic                wake_event,
  output      dcc_pkg::dcc_osc_s    osc,
  output      dcc_pkg::dcc_clk_s    clk_out
);
  import dcc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       pcc;
    logic [7:0]       osc_cfg;
    dcc_wake_e        wst;
    logic [DLY_W-1:0] dly_cnt;
    logic [7:0]       per_cnt;
    logic [7:0]       per;
    logic [7:0]       ph_cnt;
    logic [1:0]       sub;
    logic             act_slow;
    logic [1:0]       act_div;
    logic [7:0]       div_cnt;
    logic             code_ph;
    dcc_wb_rsp_s      rsp;
    dcc_osc_s         osc;
    dcc_clk_s         clk;
  } dcc_state_s;

  dcc_state_s st;
  dcc_state_s next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] div_last(input logic [1:0] code);
    logic [7:0] r;
    r = 8'h00;
    unique case (code)
      DIV_BY2:   r = 8'h01;
      DIV_BY1:   r = 8'h00;
      DIV_BY8:   r = 8'h07;
      DIV_BY256: r = 8'hff;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    return en ? new_v : old_v;
  endfunction

  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(WAKE_DELAY_CYC - 1);

  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic [7:0]  wbyte;
  logic        fast_tick;
  logic        src_tick;
  logic        div_wrap;
  logic        pclk_run;
  logic [7:0]  quarter;
  logic [7:0]  stat;

  always_comb
  begin
    next_st   = st;
    idx       = wb_req.adr[9:2];
    req       = wb_req.cyc && wb_req.stb && !st.rsp.ack;
    wr        = wb_req.cyc && wb_req.stb && st.rsp.ack &&
                wb_req.we && wb_req.sel[0];
    wbyte     = wb_req.dat[7:0];
    fast_tick = 1'b0;
    quarter   = {2'h0, st.per[7:2]};
    stat      = {4'h0, st.act_div, st.act_slow,
                 (st.wst != WS_RUN)};

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (wr && idx == REG_PWR_CLK_IDX)
      next_st.pcc = lane_merge(st.pcc, wbyte, 1'b1);
    if (wr && idx == REG_OSC_SRC_IDX)
    begin
      next_st.osc_cfg[OSC_LOCK] = wbyte[OSC_LOCK];
      if (!st.osc_cfg[OSC_LOCK])
        next_st.osc_cfg[OSC_RC_SEL] = wbyte[OSC_RC_SEL];
    end

    // --------------------------------------------------------------
    // Power-down and wakeup sequencing
    // --------------------------------------------------------------
    unique case (st.wst)
      WS_RUN:
        if (st.pcc[PCC_PDN])
          next_st.wst = WS_DOWN;
      WS_DOWN:
        if (!next_st.pcc[PCC_PDN])
          next_st.wst = WS_RUN;
        else if (wake_event)
        begin
          next_st.pcc[PCC_PDN] = 1'b0;
          if (!st.pcc[PCC_SEL_SLOW])
          begin
            next_st.pcc[PCC_FAST_DIS] = 1'b0;
            next_st.dly_cnt = '0;
            next_st.wst = WS_FAST_DLY;
          end
          else
          begin
            next_st.pcc[PCC_SLOW_EN] = 1'b1;
            next_st.wst = WS_SLOW_WAIT;
          end
        end
      WS_FAST_DLY:
        if (st.dly_cnt >= DLY_LAST)
          next_st.wst = WS_RUN;
        else
          next_st.dly_cnt = st.dly_cnt + 1'b1;
      WS_SLOW_WAIT:
        if (slow_osc_stable)
          next_st.wst = WS_RUN;
    endcase

    // --------------------------------------------------------------
    // Oscillator enables
    // --------------------------------------------------------------
    next_st.osc.fast_osc_en = !next_st.pcc[PCC_FAST_DIS];
    next_st.osc.pll_en      = !next_st.pcc[PCC_FAST_DIS];
    next_st.osc.slow_osc_en = next_st.pcc[PCC_SLOW_EN];
    next_st.osc.slow_src_rc = next_st.osc_cfg[OSC_RC_SEL];
    next_st.osc.cpu_hold    = next_st.wst == WS_FAST_DLY ||
                              next_st.wst == WS_SLOW_WAIT;
    next_st.osc.pdn         = next_st.pcc[PCC_PDN];

    // --------------------------------------------------------------
    // Times-four PLL: four evenly spaced ticks per oscillator tick
    // --------------------------------------------------------------
    if (!st.osc.pll_en)
    begin
      next_st.sub    = 2'h0;
      next_st.ph_cnt = 8'h00;
    end
    else if (fast_osc_tick)
    begin
      next_st.per     = st.per_cnt;
      next_st.per_cnt = 8'h01;
      next_st.ph_cnt  = 8'h01;
      next_st.sub     = 2'h0;
      fast_tick       = 1'b1;
    end
    else
    begin
      if (st.per_cnt != 8'hff)
        next_st.per_cnt = st.per_cnt + 1'b1;
      next_st.ph_cnt = st.ph_cnt + 1'b1;
      if (st.ph_cnt >= quarter &&
          st.sub < 2'(PLL_MULT - 1))
      begin
        fast_tick      = 1'b1;
        next_st.ph_cnt = 8'h01;
        next_st.sub    = st.sub + 1'b1;
      end
    end

    // --------------------------------------------------------------
    // Processor clock: source, divider, gating
    // --------------------------------------------------------------
    src_tick = st.act_slow ? slow_osc_tick : fast_tick;
    div_wrap = src_tick && st.div_cnt >= div_last(st.act_div);
    pclk_run = st.wst == WS_RUN && !st.pcc[PCC_PDN];
    if (src_tick)
      next_st.div_cnt = div_wrap ? 8'h00 : st.div_cnt + 1'b1;
    if (div_wrap)
    begin
      next_st.act_slow = st.pcc[PCC_SEL_SLOW];
      next_st.act_div  = st.pcc[PCC_DIV_LO+1:PCC_DIV_LO];
    end
    next_st.clk.pclk_en    = div_wrap && pclk_run;
    next_st.clk.ram_cyc_en = div_wrap && pclk_run;
    next_st.clk.code_cyc_en = div_wrap && pclk_run &&
                              st.code_ph;
    if (div_wrap && pclk_run)
      next_st.code_ph = !st.code_ph;

    // --------------------------------------------------------------
    // Functional clocks
    // --------------------------------------------------------------
    next_st.clk.fast_clk_en       = fast_tick && !st.pcc[PCC_PDN];
    next_st.clk.filter_clk_en     = fast_tick && !st.pcc[PCC_PDN];
    next_st.clk.analog_front_end_clk_en = fast_tick && !st.pcc[PCC_PDN];
    next_st.clk.l1_clk_en         = fast_tick && !st.pcc[PCC_PDN];
    next_st.clk.timer1_clk_en     = fast_tick &&
                                    !st.pcc[PCC_PDN];
    next_st.clk.timer3_clk_en     = fast_tick && !st.pcc[PCC_PDN];
    next_st.clk.mt_timer_clk_en   = fast_tick &&
                                    !st.pcc[PCC_PDN];
    next_st.clk.wdt_clk_en        = slow_osc_tick &&
                                    !st.pcc[PCC_PDN];
    next_st.clk.timer2_clk_en     = slow_osc_tick;
    next_st.clk.audio_wake_clk_en = slow_osc_tick;

    // --------------------------------------------------------------
    // Wishbone answer
    // --------------------------------------------------------------
    next_st.rsp.ack = req;
    next_st.rsp.dat = 32'h0000_0000;
    if (req && !wb_req.we)
    begin
      unique case (idx)
        REG_PWR_CLK_IDX:  next_st.rsp.dat[7:0] = st.pcc;
        REG_OSC_SRC_IDX:  next_st.rsp.dat[7:0] = st.osc_cfg;
        REG_CLK_STAT_IDX: next_st.rsp.dat[7:0] = stat;
        default:          next_st.rsp.dat = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st             <= '0;
      st.pcc         <= PCC_RESET;
      st.osc_cfg     <= OSC_SRC_RESET;
      st.wst         <= WS_RUN;
      st.act_slow    <= 1'b0;
      st.act_div     <= DIV_BY1;
      st.osc.fast_osc_en <= 1'b1;
      st.osc.pll_en  <= 1'b1;
    end
    else if (ce)
      st <= next_st;
  end

  assign wb_rsp  = st.rsp;
  assign osc     = st.osc;
  assign clk_out = st.clk;

endmodule

// ==== verification/dcc_clock_control_assertions.sv ====
// Checker for the dual oscillator clock control block
`timescale 1ns/1ns
module dcc_clock_control_assertions #(
  parameter int WAKE_DELAY_CYC = dcc_pkg::WAKE_DLY_CYC
) (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 ce,
  input wire dcc_pkg::dcc_wb_req_s wb_req,
  input wire dcc_pkg::dcc_wb_rsp_s wb_rsp,
  input wire logic                 slow_osc_tick,
  input wire logic                 slow_osc_stable,
  input wire logic                 wake_event,
  input wire dcc_pkg::dcc_osc_s    osc,
  input wire dcc_pkg::dcc_clk_s    clk_out
);
  import dcc_pkg::*;
  logic [DLY_W-1:0] hc;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Hold length while the slow source is settled
  always_ff @(posedge clk_sys)
    if (!rst_n || !osc.cpu_hold || !slow_osc_stable)
      hc <= '0;
    else if (ce)
      hc <= hc + 1'b1;
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack && ce;
  endsequence
  sequence s_down;
    osc.pdn && $past(osc.pdn);
  endsequence
  sequence s_wake;
    wake_event && ce ##0 s_down;
  endsequence
  a_ack_pulse: assert property (wb_rsp.ack && ce |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (s_req |=> wb_rsp.ack)
    else $error("request not answered");
  a_pll_follow: assert property (osc.pll_en == osc.fast_osc_en)
    else $error("pll enable differs from fast enable");
  a_pll_stop: assert property (!osc.pll_en && ce |=>
    !clk_out.fast_clk_en) else $error("fast clock with pll off");
  a_pdn_cpu: assert property (s_down |-> !clk_out.pclk_en)
    else $error("processor clock during power-down");
  a_hold_cpu: assert property (osc.cpu_hold && $past(osc.cpu_hold)
    |-> !clk_out.pclk_en) else $error("processor clock during hold");
  a_pdn_gates: assert property (s_down |-> !(clk_out.fast_clk_en
    || clk_out.filter_clk_en || clk_out.analog_front_end_clk_en
    || clk_out.l1_clk_en
    || clk_out.timer1_clk_en || clk_out.timer3_clk_en
    || clk_out.mt_timer_clk_en || clk_out.wdt_clk_en))
    else $error("functional clock during power-down");
  a_t2_runs: assert property (osc.pdn && slow_osc_tick && ce |->
    ##[1:2] (clk_out.timer2_clk_en && clk_out.audio_wake_clk_en))
    else $error("wake clocks stopped in power-down");
  a_cyc_pair: assert property (
    clk_out.ram_cyc_en == clk_out.pclk_en
    && (!clk_out.code_cyc_en || clk_out.pclk_en))
    else $error("memory cycle enable mismatch");
  a_wake_pdn: assert property (s_wake |-> ##[1:2] !osc.pdn)
    else $error("wakeup left power-down set");
  a_wake_hold: assert property (s_wake |-> ##[1:2] osc.cpu_hold)
    else $error("wakeup without hold");
  a_hold_limit: assert property (osc.cpu_hold |-> hc <= WAKE_DELAY_CYC)
    else $error("wake delay too long");
endmodule

bind dcc_clock_control dcc_clock_control_assertions #(
  .WAKE_DELAY_CYC(WAKE_DELAY_CYC)
) u_dcc_clock_control_assertions (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .slow_osc_tick(slow_osc_tick),
  .slow_osc_stable(slow_osc_stable), .wake_event(wake_event),
  .osc(osc), .clk_out(clk_out)
);

// ==== verification/dcc_clock_control_bench.sv ====
// Bench for the dual oscillator clock control block
`timescale 1ns/1ns
module dcc_clock_control_bench;
  import dcc_pkg::*;
  localparam int          WD    = 20;
  localparam int          WIN   = 4096;
  localparam logic [11:0] A_PCC = {2'h0, REG_PWR_CLK_IDX, 2'h0};
  localparam logic [11:0] A_OSC = {2'h0, REG_OSC_SRC_IDX, 2'h0};
  logic        clk_sys         = 1'b0;
  logic        rst_n           = 1'b0;
  logic        ce              = 1'b1;
  dcc_wb_req_s wb_req          = '0;
  dcc_wb_rsp_s wb_rsp;
  logic        fast_osc_tick   = 1'b0;
  logic        slow_osc_tick   = 1'b0;
  logic        slow_osc_stable = 1'b1;
  logic        wake_event      = 1'b0;
  dcc_osc_s    osc;
  dcc_clk_s    clk_out;
  logic [7:0]  q;
  logic [3:0]  tc              = 4'h0;
  logic [7:0]  sw [5]          = '{8'h04, 8'h84, 8'h80, 8'h00, 8'h00};
  logic [7:0]  sr [5]          = '{8'h04, 8'h84, 8'h84, 8'h04, 8'h00};
  int          dv [4]          = '{2, 1, 8, 256};
  int          err_count       = 0;
  int          samples_checked = 0;
  int          pc, cc, fc, wc, t2;
  always #25 clk_sys = ~clk_sys;
  // Oscillator ticks only while that oscillator is enabled
  always @(posedge clk_sys)
  begin
    tc <= tc + 4'h1;
    fast_osc_tick <= (tc[2:0] == 3'h0) && osc.fast_osc_en;
    slow_osc_tick <= (tc == 4'h5) && osc.slow_osc_en;
  end
  dcc_clock_control #(.WAKE_DELAY_CYC(WD)) u_dcc_clock_control (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .fast_osc_tick(fast_osc_tick),
    .slow_osc_tick(slow_osc_tick), .slow_osc_stable(slow_osc_stable),
    .wake_event(wake_event), .osc(osc), .clk_out(clk_out));
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkn(input string n, input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi)
    begin
      err_count++;
      $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask
  // ----------------------------------------------------------------
  // Wishbone classic access
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_rsp.ack !== 1'b1);
    chk8("ack_wait", 8'h02, n[7:0]);
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    chk8(n, e, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic cnt(input int n);
    pc = 0; cc = 0; fc = 0; wc = 0; t2 = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      pc += int'(clk_out.pclk_en === 1'b1);
      cc += int'(clk_out.code_cyc_en === 1'b1);
      fc += int'(clk_out.fast_clk_en === 1'b1);
      wc += int'(clk_out.wdt_clk_en === 1'b1);
      t2 += int'(clk_out.timer2_clk_en === 1'b1);
    end
  endtask
  task automatic hold(input int lo, input int hi);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (osc.cpu_hold === 1'b1 && n < 1000)
    begin
      n++;
      @(negedge clk_sys);
    end
    chkn("hold", lo, hi, n);
  endtask
  task automatic wake;
    @(posedge clk_sys);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    wt(3);
    rst_n <= 1'b1;
    rd(A_PCC, 8'h08, "pcc");
    rd(A_OSC, 8'h00, "osc_src");
    chk8("fast_en", 8'h01, {7'h0, osc.fast_osc_en});
    chk8("slow_en", 8'h00, {7'h0, osc.slow_osc_en});
    rd(12'h004, 8'h00, "unmapped");
    bus(1'b1, A_PCC, 8'h0b);
    wt(3);
    chk8("fast_off", 8'h00, {7'h0, osc.fast_osc_en});
    chk8("pll_off", 8'h00, {7'h0, osc.pll_en});
    chk8("slow_on", 8'h01, {7'h0, osc.slow_osc_en});
    foreach (sw[i])
    begin
      bus(1'b1, A_OSC, sw[i]);
      rd(A_OSC, sr[i], "osc_src");
      chk8("rc", {7'h0, sr[i][2]}, {7'h0, osc.slow_src_rc});
    end
    foreach (dv[i])
    begin
      bus(1'b1, A_PCC, {3'h0, i[1:0], 3'h2});
      wt(600);
      cnt(WIN);
      chkn("pclk", WIN/2/dv[i]-2, WIN/2/dv[i]+2, pc);
      chkn("code", WIN/4/dv[i]-2, WIN/4/dv[i]+2, cc);
    end
    chkn("fast_clk", WIN/2-2, WIN/2+2, fc);
    chkn("wdt_clk", WIN/16-2, WIN/16+2, wc);
    rd(A_PCC, 8'h1a, "pcc");
    bus(1'b1, A_PCC, 8'h0c);
    rd(A_PCC, 8'h0c, "pcc_dead_sel");
    bus(1'b1, A_PCC, 8'h0e);
    wt(600);
    cnt(WIN);
    chkn("slow_pclk", WIN/16-2, WIN/16+2, pc);
    chkn("slow_code", WIN/32-2, WIN/32+2, cc);
    bus(1'b1, A_PCC, 8'h0a);
    wt(600);
    bus(1'b1, A_PCC, 8'h8b);
    wt(4);
    cnt(200);
    chkn("pdn_pclk", 0, 0, pc);
    chkn("pdn_fast", 0, 0, fc);
    chkn("pdn_t2", 11, 14, t2);
    wake();
    ce <= 1'b0;
    wt(10);
    ce <= 1'b1;
    hold(WD, WD + 2);
    rd(A_PCC, 8'h0a, "pcc_wake");
    chk8("fast_back", 8'h01, {7'h0, osc.fast_osc_en});
    bus(1'b1, A_PCC, 8'h0e);
    wt(600);
    bus(1'b1, A_PCC, 8'h8d);
    slow_osc_stable <= 1'b0;
    wt(4);
    wake();
    wt(50);
    chk8("slow_wait", 8'h01, {7'h0, osc.cpu_hold});
    slow_osc_stable <= 1'b1;
    hold(0, 3);
    rd(A_PCC, 8'h0f, "pcc_slow_wake");
    conclude();
  end
  initial
  begin
    #(50 * 60000);
    err_count++;
    conclude();
  end
endmodule
